/* File: src/row_readout_pkg.sv */
/*
 package for the row readout timing block: array geometry, reset values and carriers.
 assumes nothing of its surroundings.
*/
package row_readout_pkg;
    localparam int ROWS = 512;
    localparam int COLS = 512;
    localparam int ADDR_W = 9;
    localparam logic [8:0] START_RESET = 9'h000;
    localparam logic [8:0] POINTER_RESET = 9'h000;
    localparam logic [8:0] LAST_POS = 9'h1ff;

    // strobes from the external timing controller, sampled on clk
    typedef struct packed {
        logic read_row_preset;
        logic reset_row_preset;
        logic read_row_step;
        logic reset_row_step;
        logic column_preset;
        logic pixel_clock;
        logic column_start_load;
        logic row_start_load;
        logic row_side_select;
        logic row_select;
        logic row_reset;
        logic offset_cal;
        logic signal_sample;
        logic reference_sample;
    } ctrl_t;

    typedef struct packed {
        logic column_scan_end;
        logic read_row_scan_end;
        logic reset_row_scan_end;
    } scan_end_t;
endpackage : row_readout_pkg

/* File: src/scan_pointer.sv */
/*
 one scan pointer: preset from a start value, step by one, pulse at the final position.
 assumes preset and step are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ns
module scan_pointer
    import row_readout_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter logic [WIDTH-1:0] LAST = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic preset,
    input wire logic step,
    input wire logic [WIDTH-1:0] start,
    output logic [WIDTH-1:0] pos_q,
    output logic scan_end_q
);
    initial begin
        if (WIDTH < 1) $error("scan_pointer width must be at least one");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_q <= '0;
        end else if (preset) begin
            pos_q <= start;
        end else if (step) begin
            pos_q <= (pos_q == LAST) ? '0 : pos_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_end_q <= 1'b0;
        end else begin
            scan_end_q <= step && !preset && (pos_q == LAST);
        end
    end

    a_end_pulse: assert property (@(posedge clk) disable iff (rst)
        (step && !preset && pos_q == LAST) |=> scan_end_q && pos_q == '0)
        else $error("scan end pulse missing at final position");
    a_preset_wins: assert property (@(posedge clk) disable iff (rst)
        preset |=> pos_q == $past(start))
        else $error("preset did not load start value");
endmodule : scan_pointer

/* File: src/row_readout.sv */
/*
 row and pixel readout sequencing of a 512 x 512 sensor array, driven by an external
 timing controller. pointers, start registers, pixel strobing, calibration path.
 assumes all controller strobes are synchronous to clk and held for at least one cycle.
*/
// How it works
// - row readout starts by presetting or stepping the read row pointer.
// - after blanking, row pixels go out one by one selected by column pointer.
// - start address loaded by strobe, applied at next matching preset.
// - next pixel on pixel clock fall; output held low, updates after rise.
// - row select low inhibits pixel array operation.
// - calibration high disconnects array, unity gain, black reference feeds amplifier.
// - each shift register pulses its scan end at final position.
// - side select high acts on read side, low on reset side.
`timescale 1ns/1ns
module row_readout
    import row_readout_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input ctrl_t ctrl,
    input wire logic [AW-1:0] start_addr,
    output logic [AW-1:0] read_row_pointer,
    output logic [AW-1:0] reset_row_pointer,
    output logic [AW-1:0] column_pointer,
    output logic read_row_active_q,
    output logic reset_row_active_q,
    output logic pixel_valid_q,
    output logic [AW-1:0] pixel_col_q,
    output logic [AW-1:0] pixel_row_q,
    output logic amp_from_black_q,
    output logic amp_unity_gain_q,
    output scan_end_t scan_end
);
    initial begin
        if (AW != ADDR_W) $error("address width must match the array geometry");
    end

    logic [AW-1:0] col_start_q;
    logic [AW-1:0] row_start_q;
    logic pix_clk_q;
    logic pix_fall;
    logic col_step;
    logic col_preset;

    // start registers: loaded now, used only at the next preset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            col_start_q <= START_RESET;
        end else if (ctrl.column_start_load) begin
            col_start_q <= start_addr;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            row_start_q <= START_RESET;
        end else if (ctrl.row_start_load) begin
            row_start_q <= start_addr;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pix_clk_q <= 1'b0;
        end else begin
            pix_clk_q <= ctrl.pixel_clock;
        end
    end

    assign pix_fall = pix_clk_q && !ctrl.pixel_clock;
    assign col_preset = ctrl.column_preset && ctrl.pixel_clock;
    assign col_step = pix_fall && !col_preset;

    scan_pointer #(.WIDTH(AW), .LAST(LAST_POS)) u_read_row (
        .clk(clk),
        .rst(rst),
        .preset(ctrl.read_row_preset),
        .step(ctrl.read_row_step),
        .start(row_start_q),
        .pos_q(read_row_pointer),
        .scan_end_q(scan_end.read_row_scan_end)
    );

    scan_pointer #(.WIDTH(AW), .LAST(LAST_POS)) u_reset_row (
        .clk(clk),
        .rst(rst),
        .preset(ctrl.reset_row_preset),
        .step(ctrl.reset_row_step),
        .start(row_start_q),
        .pos_q(reset_row_pointer),
        .scan_end_q(scan_end.reset_row_scan_end)
    );

    scan_pointer #(.WIDTH(AW), .LAST(LAST_POS)) u_column (
        .clk(clk),
        .rst(rst),
        .preset(col_preset),
        .step(col_step),
        .start(col_start_q),
        .pos_q(column_pointer),
        .scan_end_q(scan_end.column_scan_end)
    );

    // row drive: side select steers select to one register; reset reaches the reset side only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_row_active_q <= 1'b0;
            reset_row_active_q <= 1'b0;
        end else begin
            read_row_active_q <= ctrl.row_select && ctrl.row_side_select;
            reset_row_active_q <= ctrl.row_select && !ctrl.row_side_select
                && ctrl.row_reset;
        end
    end

    // pixel output: held while clock low, new pixel presented after rise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pixel_valid_q <= 1'b0;
            pixel_col_q <= POINTER_RESET;
            pixel_row_q <= POINTER_RESET;
        end else if (ctrl.pixel_clock && !pix_clk_q) begin
            pixel_valid_q <= ctrl.row_select && !ctrl.offset_cal;
            pixel_col_q <= column_pointer;
            pixel_row_q <= read_row_pointer;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            amp_from_black_q <= 1'b0;
            amp_unity_gain_q <= 1'b0;
        end else begin
            amp_from_black_q <= ctrl.offset_cal;
            amp_unity_gain_q <= ctrl.offset_cal;
        end
    end

    a_load_deferred: assert property (@(posedge clk) disable iff (rst)
        (ctrl.row_start_load && !ctrl.read_row_preset && !ctrl.read_row_step)
        |=> $stable(read_row_pointer))
        else $error("row start load changed pointer without preset");
    a_col_step: assert property (@(posedge clk) disable iff (rst)
        (pix_fall && !col_preset && column_pointer != LAST_POS)
        |=> column_pointer == $past(column_pointer) + 9'h001)
        else $error("column pointer did not step on pixel clock fall");
    a_pix_hold: assert property (@(posedge clk) disable iff (rst)
        (!ctrl.pixel_clock && !pix_clk_q) |=> $stable(pixel_col_q))
        else $error("pixel output changed while clock low");
    a_select_inhibit: assert property (@(posedge clk) disable iff (rst)
        !ctrl.row_select |=> !read_row_active_q && !reset_row_active_q)
        else $error("row drive while select low");
    a_cal_path: assert property (@(posedge clk) disable iff (rst)
        ctrl.offset_cal |=> amp_from_black_q && amp_unity_gain_q)
        else $error("calibration did not switch amplifier");
    a_cal_blank: assert property (@(posedge clk) disable iff (rst)
        (ctrl.offset_cal && ctrl.pixel_clock && !pix_clk_q) |=> !pixel_valid_q)
        else $error("pixel valid during calibration");
    a_side_read: assert property (@(posedge clk) disable iff (rst)
        (ctrl.row_select && ctrl.row_side_select)
        |=> read_row_active_q && !reset_row_active_q)
        else $error("side select high did not pick read side");
    a_read_preset: assert property (@(posedge clk) disable iff (rst)
        ctrl.read_row_preset |=> read_row_pointer == $past(row_start_q))
        else $error("read preset did not load row start");
    a_col_preset: assert property (@(posedge clk) disable iff (rst)
        (ctrl.column_preset && !ctrl.pixel_clock && !pix_clk_q)
        |=> $stable(column_pointer))
        else $error("column preset accepted while pixel clock low");
endmodule : row_readout

/* File: tb/timing_ctrl_model.sv */
/*
 timing controller model: drives the controller strobes and the shared start address.
 assumes apply is called once per cycle, just after a rising edge of clk.
*/
`timescale 1ns/1ns
module timing_ctrl_model
    import row_readout_pkg::*;
(
    input wire logic clk,
    output ctrl_t ctrl,
    output logic [8:0] start_addr
);
    localparam logic [13:0] SEL = 14'h0010, SIDE = 14'h0020, ROW_RST = 14'h0008,
        CAL = 14'h0004, SIG = 14'h0002, REF = 14'h0001;

    initial begin
        ctrl = '0;
        start_addr = 9'h000;
    end

    // one cycle of strobes; without a load the address bus shows the inverse of its previous value
    task automatic apply(input logic [13:0] bits, input logic [8:0] addr);
        ctrl = bits;
        start_addr = (bits[7] || bits[6]) ? addr : ~start_addr;
        @(posedge clk);
        #1;
    endtask : apply

    // one row initialisation: pointer move, calibration, double sampling, two resets
    task automatic blank(input logic [13:0] move, input logic cal);
        apply(move | SEL, 9'h000);
        repeat (5) apply(SEL, 9'h000);
        repeat (25) apply(cal ? (SEL | CAL) : SEL, 9'h000);
        repeat (6) apply(SEL, 9'h000);
        repeat (10) apply(SEL | SIG, 9'h000);
        apply(SEL, 9'h000);
        repeat (3) apply(SEL | ROW_RST, 9'h000);
        repeat (10) apply(SEL, 9'h000);
        repeat (10) apply(SEL | REF, 9'h000);
        apply(SEL, 9'h000);
        apply(SEL | SIDE, 9'h000);
        repeat (3) apply(SEL | SIDE | ROW_RST, 9'h000);
        apply(SEL | SIDE, 9'h000);
        apply(SEL, 9'h000);
    endtask : blank
endmodule : timing_ctrl_model

/* File: tb/row_readout_test.sv */
/*
 self-checking bench for row_readout: pointers, pixel strobing, wrap, calibration path.
 assumes the controller model applies one strobe word per clock cycle.
*/
`timescale 1ns/1ns
module row_readout_test
    import row_readout_pkg::*;
;
    localparam logic [13:0] RD_PRE = 14'h2000, RS_PRE = 14'h1000, RD_STEP = 14'h0800,
        RS_STEP = 14'h0400, COL_PRE = 14'h0200, PIX_CLK = 14'h0100, COL_LD = 14'h0080,
        ROW_LD = 14'h0040, SIDE_RD = 14'h0020, ROW_SEL = 14'h0010, ROW_RST = 14'h0008,
        CAL = 14'h0004;
    localparam logic [8:0] ROW_FIRST = 9'h010, COL_FIRST = 9'h020;
    localparam int WIN_H = 4, WIN_W = 4, DELAY = 3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ctrl_t ctrl;
    logic [8:0] start_addr, rd_ptr, rs_ptr, col_ptr, pix_col, pix_row;
    logic rd_act, rs_act, pix_valid, from_black, unity;
    scan_end_t scan_end;
    int fails = 0;
    int checks = 0;

    always #20 clk = ~clk;

    timing_ctrl_model ctl (.clk(clk), .ctrl(ctrl), .start_addr(start_addr));

    row_readout uut (
        .clk(clk), .rst(rst), .ctrl(ctrl), .start_addr(start_addr),
        .read_row_pointer(rd_ptr), .reset_row_pointer(rs_ptr), .column_pointer(col_ptr),
        .read_row_active_q(rd_act), .reset_row_active_q(rs_act),
        .pixel_valid_q(pix_valid), .pixel_col_q(pix_col), .pixel_row_q(pix_row),
        .amp_from_black_q(from_black), .amp_unity_gain_q(unity), .scan_end(scan_end)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic test_rows();
        ctl.apply(ROW_LD | ROW_SEL, 9'h005);
        check(rd_ptr, 9'h000);
        ctl.apply(RD_PRE | ROW_SEL, 9'h000);
        check(rd_ptr, 9'h005);
        ctl.apply(RD_STEP | RS_PRE | ROW_SEL, 9'h000);
        check({rd_ptr, rs_ptr}, {9'h006, 9'h005});
        ctl.apply(RD_PRE | RD_STEP | ROW_SEL, 9'h000);
        check(rd_ptr, 9'h005);
        $display("rows done");
    endtask : test_rows

    task automatic test_pixel();
        ctl.apply(COL_LD | ROW_SEL, 9'h003);
        ctl.apply(PIX_CLK | ROW_SEL, 9'h000);
        ctl.apply(PIX_CLK | COL_PRE | ROW_SEL, 9'h000);
        check(col_ptr, 9'h003);
        ctl.apply(ROW_SEL, 9'h000);
        check(col_ptr, 9'h004);
        ctl.apply(COL_PRE | ROW_SEL, 9'h000);
        check(col_ptr, 9'h004);
        ctl.apply(PIX_CLK | ROW_SEL, 9'h000);
        check({pix_valid, pix_col, pix_row}, {1'b1, 9'h004, 9'h005});
        ctl.apply(ROW_SEL, 9'h000);
        check({col_ptr, pix_col}, {9'h005, 9'h004});
        $display("pixel done");
    endtask : test_pixel

    task automatic test_wrap();
        ctl.apply(ROW_LD | COL_LD | ROW_SEL, 9'h1ff);
        ctl.apply(RD_PRE | RS_PRE | COL_PRE | PIX_CLK | ROW_SEL, 9'h000);
        check({rd_ptr, rs_ptr, col_ptr}, {9'h1ff, 9'h1ff, 9'h1ff});
        ctl.apply(RD_STEP | RS_STEP | ROW_SEL, 9'h000);
        check({rd_ptr, rs_ptr, col_ptr}, 32'h0);
        check(scan_end, 3'b111);
        ctl.apply(ROW_SEL, 9'h000);
        check(scan_end, 3'b000);
        $display("wrap done");
    endtask : test_wrap

    task automatic test_misc();
        ctl.apply(CAL | SIDE_RD | ROW_SEL, 9'h000);
        check({from_black, unity, rd_act, rs_act}, 4'b1110);
        ctl.apply(SIDE_RD, 9'h000);
        check({from_black, unity, rd_act}, 3'b000);
        ctl.apply(ROW_RST | ROW_SEL, 9'h000);
        check({rd_act, rs_act}, 2'b01);
        ctl.apply(ROW_RST, 9'h000);
        check(rs_act, 1'b0);
        ctl.apply(ROW_SEL, 9'h000);
        ctl.apply(CAL | PIX_CLK | ROW_SEL, 9'h000);
        check({pix_valid, from_black}, 2'b01);
        ctl.apply(ROW_SEL, 9'h000);
        ctl.apply(PIX_CLK, 9'h000);
        check(pix_valid, 1'b0);
        ctl.apply(ROW_SEL, 9'h000);
        $display("misc done");
    endtask : test_misc

    // DELAY rows of exposure in a WIN_H by WIN_W window, two and a half frames
    task automatic test_frame();
        logic [13:0] move;
        logic [8:0] exp_rd;
        logic [8:0] gap;
        exp_rd = ROW_FIRST;
        ctl.apply(ROW_LD | ROW_SEL, ROW_FIRST);
        ctl.apply(COL_LD | ROW_SEL, COL_FIRST);
        for (int j = 0; j < 10; j++) begin
            move = (j % WIN_H == 0) ? RS_PRE : RS_STEP;
            if (j >= DELAY - 1) begin
                move = move | (((j - DELAY + 1) % WIN_H == 0) ? RD_PRE : RD_STEP);
                exp_rd = ROW_FIRST + 9'((j - DELAY + 1) % WIN_H);
            end else begin
                move = move | RD_STEP;
            end
            ctl.blank(move, (move & RD_PRE) != 14'h0000);
            check(rs_ptr, ROW_FIRST + 9'(j % WIN_H));
            ctl.apply(PIX_CLK | COL_PRE | ROW_SEL, 9'h000);
            for (int i = 1; i <= WIN_W; i++) begin
                ctl.apply(ROW_SEL, 9'h000);
                ctl.apply(PIX_CLK | ROW_SEL, 9'h000);
                check({pix_valid, pix_col}, {1'b1, COL_FIRST + 9'(i)});
            end
            ctl.apply(ROW_SEL, 9'h000);
            if (j >= DELAY - 1) begin
                gap = rs_ptr - rd_ptr;
                check({rd_ptr, pix_row}, {exp_rd, exp_rd});
                check(32'(gap % 9'(WIN_H)) + 32'h1, 32'(DELAY));
            end
        end
        $display("frame done");
    endtask : test_frame

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check({rd_ptr, rs_ptr, col_ptr, scan_end, pix_valid}, 32'h0);
        test_rows();
        test_pixel();
        test_wrap();
        test_misc();
        test_frame();
        close_out();
    end

    // cuts a hang short
    initial begin
        #200000;
        fails++;
        close_out();
    end
endmodule : row_readout_test
